// ---- design/sdf_defines.svh ----
// sdf_defines.svh: offsets, field positions, reset values and timing counts
// assumes a 25 MHz system clock and a 32-bit AXI4-Lite register bus
`ifndef SDF_DEFINES_SVH
`define SDF_DEFINES_SVH

// ----------------------------------------------------------------------
// clock and timing
// ----------------------------------------------------------------------
`define SDF_CLK_HZ 25000000
`define SDF_CYC_PER_MS (`SDF_CLK_HZ / 1000)
`define SDF_OVLD_MS 5000
`define SDF_OVLD_CYC (`SDF_OVLD_MS * `SDF_CYC_PER_MS)
`define SDF_BLINK_MS 200
`define SDF_BLINK_CYC (`SDF_BLINK_MS * `SDF_CYC_PER_MS)
`define SDF_PAUSE_MS 1200
`define SDF_PAUSE_CYC (`SDF_PAUSE_MS * `SDF_CYC_PER_MS)
`define SDF_OSPD_RPM 16'h1388

// ----------------------------------------------------------------------
// register offsets (byte addresses)
// ----------------------------------------------------------------------
`define SDF_CTRL_OFS 8'h00
`define SDF_STATUS_OFS 8'h04
`define SDF_IRQ_STAT_OFS 8'h08
`define SDF_IRQ_EN_OFS 8'h0c
`define SDF_IRQ_CLR_OFS 8'h10

// ----------------------------------------------------------------------
// field positions and reset values
// ----------------------------------------------------------------------
`define SDF_CTRL_CLR_BIT 0
`define SDF_ST_CODE_LSB 0
`define SDF_ST_HEALTHY_BIT 4
`define SDF_ST_CUR_EN_BIT 5
`define SDF_ST_CUR_DIAL_LSB 8
`define SDF_ST_FILT_DIAL_LSB 12
`define SDF_ST_PCT_LSB 16
`define SDF_IRQ_SET_BIT 0
`define SDF_IRQ_CLR_BIT 1
`define SDF_CUR_DIAL_DEF 4'hf
`define SDF_FILT_DIAL_DEF 4'h6
`define SDF_RESP_OKAY 2'h0
`define SDF_RESP_SLVERR 2'h2

`endif

// ---- design/sdf_pkg.sv ----
// sdf_pkg: types of the drive settings and fault logic
// assumes sdf_defines.svh is on the include path
`default_nettype none
package sdf_pkg;

  typedef enum logic [3:0] {
    FLT_NONE = 4'h0,
    FLT_OVLD = 4'h2,
    FLT_OVV = 4'h3,
    FLT_SPD = 4'h4,
    FLT_OSPD = 4'h6,
    FLT_MEM = 4'h7,
    FLT_SNS = 4'h8,
    FLT_SYS = 4'hf
  } sdf_fault_t;

  typedef enum logic [3:0] {
    BL_IDLE = 4'b0001,
    BL_ON = 4'b0010,
    BL_OFF = 4'b0100,
    BL_PAUSE = 4'b1000
  } sdf_blink_st_t;

  typedef struct packed {
    sdf_blink_st_t st;
    logic [31:0] cnt;
    logic [3:0] done;
    logic led;
  } sdf_blink_t;

  typedef struct packed {
    sdf_fault_t fault;
    logic clr_prev;
    logic pwr_chk;
    logic [31:0] ovld_cnt;
    logic [6:0] cur_pct;
    logic [13:0] filt_tc;
    logic cur_en;
    logic healthy;
    logic [1:0] irq_stat;
    logic [1:0] irq_en;
    logic irq;
    logic aw_got;
    logic w_got;
    logic [7:0] awaddr;
    logic [31:0] wdata;
    logic wstrb0;
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } sdf_top_t;

endpackage : sdf_pkg
`default_nettype wire

// ---- design/sdf_blink.sv ----
// sdf_blink: fault lamp driver, blinks the fault code in groups, lit solid for FLT_SYS
// assumes code is the next-state fault code of the top, held while active
`include "sdf_defines.svh"
`default_nettype none
module sdf_blink import sdf_pkg::*; #(
  parameter int unsigned ON_CYC = `SDF_BLINK_CYC,
  parameter int unsigned PAUSE_CYC = `SDF_PAUSE_CYC
) (
  input wire logic clk,
  input wire logic rstn,
  input wire sdf_fault_t code,
  output logic led
);

  sdf_blink_t s_q;
  sdf_blink_t s_d;

  // ----------------------------------------------------------------------
  // group sequencer
  // ----------------------------------------------------------------------
  always_comb begin
    s_d = s_q;
    s_d.cnt = s_q.cnt + 32'h1;
    if (code == FLT_NONE) begin
      s_d = '{st: BL_IDLE, cnt: 32'h0, done: 4'h0, led: 1'b0};
    end else if (code == FLT_SYS) begin
      s_d = '{st: BL_IDLE, cnt: 32'h0, done: 4'h0, led: 1'b1};
    end else begin
      unique case (s_q.st)
        BL_IDLE: begin
          s_d = '{st: BL_ON, cnt: 32'h0, done: 4'h0, led: 1'b1};
        end
        BL_ON: begin
          if (s_q.cnt == ON_CYC - 1) begin
            s_d.cnt = 32'h0;
            s_d.done = 4'(s_q.done + 4'h1);
            s_d.led = 1'b0;
            s_d.st = (4'(s_q.done + 4'h1) >= code) ? BL_PAUSE : BL_OFF;
          end
        end
        BL_OFF: begin
          if (s_q.cnt == ON_CYC - 1) begin
            s_d.cnt = 32'h0;
            s_d.led = 1'b1;
            s_d.st = BL_ON;
          end
        end
        BL_PAUSE: begin
          if (s_q.cnt == PAUSE_CYC - 1) begin
            s_d = '{st: BL_ON, cnt: 32'h0, done: 4'h0, led: 1'b1};
          end
        end
        default: begin
          s_d = '{st: BL_IDLE, cnt: 32'h0, done: 4'h0, led: 1'b0};
        end
      endcase
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      s_q <= '{st: BL_IDLE, cnt: 32'h0, done: 4'h0, led: 1'b0};
    end else begin
      s_q <= s_d;
    end
  end

  assign led = s_q.led;

endmodule : sdf_blink
`default_nettype wire

// ---- design/sdf_top.sv ----
// sdf_top: stepper drive settings decode, fault latch and register slave
// assumes all pins synchronous to clk; power cycle appears as rstn
//
// Register access over AXI4-Lite and the register addresses were left to the implementer.
`include "sdf_defines.svh"
`default_nettype none

module sdf_top import sdf_pkg::*; #(
  parameter int unsigned OVLD_CYC = `SDF_OVLD_CYC,
  parameter int unsigned BLINK_CYC = `SDF_BLINK_CYC,
  parameter int unsigned PAUSE_CYC = `SDF_PAUSE_CYC
) (
  input wire logic clk,
  input wire logic rstn,
  input wire logic [3:0] current_level_dial,
  input wire logic [3:0] filter_dial,
  input wire logic fault_clear_input,
  input wire logic overload_det,
  input wire logic overvoltage_det,
  input wire logic speed_error_det,
  input wire logic [15:0] shaft_rpm,
  input wire logic param_corrupt_det,
  input wire logic motor_cable_present,
  input wire logic system_fail_det,
  output logic [6:0] current_pct,
  output logic motor_current_en,
  output logic [13:0] filter_tc,
  output logic healthy,
  output logic fault_led,
  output logic irq,
  input wire logic [7:0] awaddr,
  input wire logic [2:0] awprot,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  input wire logic [7:0] araddr,
  input wire logic [2:0] arprot,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready
);

  sdf_top_t s_q;
  sdf_top_t s_d;
  sdf_fault_t det;
  logic aw_ok;
  logic w_ok;
  logic wr_go;
  logic [7:0] wr_addr;
  logic [31:0] wr_data;
  logic wr_b0;
  logic sw_clr;
  logic [1:0] irq_clr;
  logic clr_ev;
  logic [31:0] rd;

  // ----------------------------------------------------------------------
  // dial and register decode
  // ----------------------------------------------------------------------
  // dial to percent table
  function automatic logic [6:0] sdf_cur_pct(input logic [3:0] dial);
    logic [6:0] p;
    p = 7'h64;
    unique case (dial)
      4'h0: p = 7'h06;
      4'h1: p = 7'h0d;
      4'h2: p = 7'h13;
      4'h3: p = 7'h19;
      4'h4: p = 7'h1f;
      4'h5: p = 7'h26;
      4'h6: p = 7'h2c;
      4'h7: p = 7'h32;
      4'h8: p = 7'h38;
      4'h9: p = 7'h3f;
      4'ha: p = 7'h45;
      4'hb: p = 7'h4b;
      4'hc: p = 7'h51;
      4'hd: p = 7'h58;
      4'he: p = 7'h5e;
      4'hf: p = 7'h64;
    endcase
    return p;
  endfunction : sdf_cur_pct

  function automatic logic [13:0] sdf_filt_tc(input logic [3:0] dial);
    logic [13:0] t;
    t = 14'h0;
    unique case (dial)
      4'h0: t = 14'h0;
      4'h1: t = 14'h00c;
      4'h2: t = 14'h010;
      4'h3: t = 14'h01b;
      4'h4: t = 14'h029;
      4'h5: t = 14'h052;
      4'h6: t = 14'h078;
      4'h7: t = 14'h0a0;
      4'h8: t = 14'h10e;
      4'h9: t = 14'h19a;
      4'ha: t = 14'h334;
      4'hb: t = 14'h4b0;
      4'hc: t = 14'h640;
      4'hd: t = 14'ha8c;
      4'he: t = 14'h1004;
      4'hf: t = 14'h2008;
    endcase
    return t;
  endfunction : sdf_filt_tc

  // faults that the clear input may release
  function automatic logic sdf_clearable(input sdf_fault_t f);
    return (f != FLT_MEM) && (f != FLT_SYS) && (f != FLT_NONE);
  endfunction : sdf_clearable

  // register index of a byte offset
  function automatic logic [5:0] sdf_idx(input logic [7:0] ofs);
    return ofs[7:2];
  endfunction : sdf_idx

  // ----------------------------------------------------------------------
  // protection detection
  // ----------------------------------------------------------------------
  always_comb begin
    det = FLT_NONE;
    if (system_fail_det) begin
      det = FLT_SYS;
    end else if (param_corrupt_det) begin
      det = FLT_MEM;
    end else if (s_q.pwr_chk && !motor_cable_present) begin
      det = FLT_SNS;
    end else if (overvoltage_det) begin
      det = FLT_OVV;
    end else if (shaft_rpm > `SDF_OSPD_RPM) begin
      det = FLT_OSPD;
    end else if (speed_error_det) begin
      det = FLT_SPD;
    end else if (overload_det && s_q.ovld_cnt == OVLD_CYC - 1) begin
      det = FLT_OVLD;
    end
  end

  // ----------------------------------------------------------------------
  // register write decode
  // ----------------------------------------------------------------------
  always_comb begin
    aw_ok = s_q.aw_got || (awvalid && s_q.awready);
    w_ok = s_q.w_got || (wvalid && s_q.wready);
    wr_go = aw_ok && w_ok && !s_q.bvalid;
    wr_addr = s_q.aw_got ? s_q.awaddr : awaddr;
    wr_data = s_q.w_got ? s_q.wdata : wdata;
    wr_b0 = s_q.w_got ? s_q.wstrb0 : wstrb[0];
    sw_clr = wr_go && wr_b0 && wr_addr[7:2] == sdf_idx(`SDF_CTRL_OFS) &&
             wr_data[`SDF_CTRL_CLR_BIT];
    irq_clr = 2'h0;
    if (wr_go && wr_b0 && wr_addr[7:2] == sdf_idx(`SDF_IRQ_CLR_OFS)) begin
      irq_clr = wr_data[1:0];
    end
  end

  // ----------------------------------------------------------------------
  // read data mux
  // ----------------------------------------------------------------------
  always_comb begin
    rd = 32'h0;
    unique case (araddr[7:2])
      sdf_idx(`SDF_STATUS_OFS): begin
        rd[`SDF_ST_CODE_LSB +: 4] = s_q.fault;
        rd[`SDF_ST_HEALTHY_BIT] = s_q.healthy;
        rd[`SDF_ST_CUR_EN_BIT] = s_q.cur_en;
        rd[`SDF_ST_CUR_DIAL_LSB +: 4] = current_level_dial;
        rd[`SDF_ST_FILT_DIAL_LSB +: 4] = filter_dial;
        rd[`SDF_ST_PCT_LSB +: 7] = s_q.cur_pct;
      end
      sdf_idx(`SDF_IRQ_STAT_OFS): begin
        rd[1:0] = s_q.irq_stat;
      end
      sdf_idx(`SDF_IRQ_EN_OFS): begin
        rd[1:0] = s_q.irq_en;
      end
      default: begin
        rd = 32'h0;
      end
    endcase
  end

  // ----------------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------------
  always_comb begin
    s_d = s_q;
    s_d.pwr_chk = 1'b0;
    s_d.clr_prev = fault_clear_input;
    clr_ev = (fault_clear_input && !s_q.clr_prev) || sw_clr;

    if (overload_det) begin
      if (s_q.ovld_cnt != OVLD_CYC - 1) begin
        s_d.ovld_cnt = s_q.ovld_cnt + 32'h1;
      end
    end else begin
      s_d.ovld_cnt = 32'h0;
    end

    if (clr_ev && sdf_clearable(s_q.fault)) begin
      s_d.fault = FLT_NONE;
    end
    // keep first fault, new detect wins over clear
    if (s_d.fault == FLT_NONE && det != FLT_NONE) begin
      s_d.fault = det;
    end

    s_d.cur_en = (s_d.fault == FLT_NONE);
    s_d.healthy = (s_d.fault == FLT_NONE);
    s_d.cur_pct = s_d.cur_en ? sdf_cur_pct(current_level_dial) : 7'h0;
    s_d.filt_tc = sdf_filt_tc(filter_dial);

    s_d.irq_stat = s_q.irq_stat & ~irq_clr;
    if (s_q.fault == FLT_NONE && s_d.fault != FLT_NONE) begin
      s_d.irq_stat[`SDF_IRQ_SET_BIT] = 1'b1;
    end
    if (s_q.fault != FLT_NONE && s_d.fault == FLT_NONE) begin
      s_d.irq_stat[`SDF_IRQ_CLR_BIT] = 1'b1;
    end
    if (wr_go && wr_b0 && wr_addr[7:2] == sdf_idx(`SDF_IRQ_EN_OFS)) begin
      s_d.irq_en = wr_data[1:0];
    end
    s_d.irq = |(s_d.irq_stat & s_d.irq_en);

    // write channel
    if (awvalid && s_q.awready) begin
      s_d.aw_got = 1'b1;
      s_d.awaddr = awaddr;
    end
    if (wvalid && s_q.wready) begin
      s_d.w_got = 1'b1;
      s_d.wdata = wdata;
      s_d.wstrb0 = wstrb[0];
    end
    if (wr_go) begin
      s_d.aw_got = 1'b0;
      s_d.w_got = 1'b0;
      s_d.bvalid = 1'b1;
      s_d.bresp = `SDF_RESP_SLVERR;
      if (wr_addr[7:2] <= sdf_idx(`SDF_IRQ_CLR_OFS) &&
          wr_addr[7:2] != sdf_idx(`SDF_STATUS_OFS) &&
          wr_addr[7:2] != sdf_idx(`SDF_IRQ_STAT_OFS)) begin
        s_d.bresp = `SDF_RESP_OKAY;
      end
    end else if (s_q.bvalid && bready) begin
      s_d.bvalid = 1'b0;
    end
    s_d.awready = !s_d.aw_got && !s_d.bvalid;
    s_d.wready = !s_d.w_got && !s_d.bvalid;

    // read channel
    if (arvalid && s_q.arready) begin
      s_d.rvalid = 1'b1;
      s_d.rdata = rd;
      s_d.rresp = (araddr[7:2] <= sdf_idx(`SDF_IRQ_CLR_OFS)) ?
                  `SDF_RESP_OKAY : `SDF_RESP_SLVERR;
    end else if (s_q.rvalid && rready) begin
      s_d.rvalid = 1'b0;
    end
    s_d.arready = !s_d.rvalid;
  end

  // ----------------------------------------------------------------------
  // state register
  // ----------------------------------------------------------------------
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      s_q <= '0;
      s_q.fault <= FLT_NONE;
      s_q.pwr_chk <= 1'b1;
      s_q.cur_pct <= sdf_cur_pct(`SDF_CUR_DIAL_DEF);
      s_q.filt_tc <= sdf_filt_tc(`SDF_FILT_DIAL_DEF);
    end else begin
      s_q <= s_d;
    end
  end

  // ----------------------------------------------------------------------
  // fault lamp
  // ----------------------------------------------------------------------
  sdf_blink #(
    .ON_CYC(BLINK_CYC),
    .PAUSE_CYC(PAUSE_CYC)
  ) sdf_blink_i (
    .clk(clk),
    .rstn(rstn),
    .code(s_d.fault),
    .led(fault_led)
  );

  // ----------------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------------
  assign current_pct = s_q.cur_pct;
  assign motor_current_en = s_q.cur_en;
  assign filter_tc = s_q.filt_tc;
  assign healthy = s_q.healthy;
  assign irq = s_q.irq;
  assign awready = s_q.awready;
  assign wready = s_q.wready;
  assign bvalid = s_q.bvalid;
  assign bresp = s_q.bresp;
  assign arready = s_q.arready;
  assign rvalid = s_q.rvalid;
  assign rdata = s_q.rdata;
  assign rresp = s_q.rresp;

endmodule : sdf_top
`default_nettype wire

// ---- testbench/sdf_ctl_model.sv ----
// sdf_ctl_model: pulse controller model driving the fault clear line
// assumes go is a one-cycle request synchronous to clk
`default_nettype none
module sdf_ctl_model (
  input wire logic clk,
  input wire logic rstn,
  input wire logic go,
  input wire logic [3:0] len,
  output logic clr
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [3:0] cnt_q;
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      cnt_q <= 4'h0;
    end else if (go) begin
      cnt_q <= len;
    end else if (cnt_q != 4'h0) begin
      cnt_q <= cnt_q - 4'h1;
    end
  end
  assign clr = (cnt_q != 4'h0);
endmodule : sdf_ctl_model
`default_nettype wire

// ---- testbench/sdf_top_props.sv ----
// sdf_top_props: checker of fault and settings outputs of sdf_top
// assumes a bind to sdf_top with its overload count
`default_nettype none
module sdf_top_props #(
  parameter int unsigned OVLD_CYC = 20
) (
  input wire logic clk,
  input wire logic rstn,
  input wire logic fault_clear_input,
  input wire logic overload_det,
  input wire logic overvoltage_det,
  input wire logic speed_error_det,
  input wire logic [15:0] shaft_rpm,
  input wire logic param_corrupt_det,
  input wire logic motor_cable_present,
  input wire logic system_fail_det,
  input wire logic [6:0] current_pct,
  input wire logic motor_current_en,
  input wire logic healthy,
  input wire logic fault_led,
  input wire logic awvalid,
  input wire logic wvalid,
  input wire logic bvalid
);
  timeunit 1ns;
  timeprecision 1ps;
  logic up_q, mem_q, sys_q, det, oth;
  logic [31:0] ovc_q;
  assign det = overvoltage_det | speed_error_det | param_corrupt_det | system_fail_det
    | (shaft_rpm > 16'h1388);
  assign oth = det | !motor_cable_present;
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      up_q <= 1'b0;
      mem_q <= 1'b0;
      sys_q <= 1'b0;
      ovc_q <= 32'h0;
    end else begin
      up_q <= 1'b1;
      mem_q <= mem_q | ((healthy | !up_q) & (param_corrupt_det | system_fail_det));
      sys_q <= sys_q | ((healthy | !up_q) & system_fail_det);
      ovc_q <= overload_det ? ovc_q + 32'h1 : 32'h0;
    end
  end
  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rstn);
  AST_CUT: assert property (up_q && !healthy |-> current_pct == 7'h00 && !motor_current_en)
    else $error("current on while faulted");
  AST_HLT: assert property (healthy |-> motor_current_en && current_pct != 7'h00)
    else $error("healthy without current");
  AST_DET: assert property ((healthy || !up_q) && det |=> !healthy && fault_led)
    else $error("detection not latched");
  AST_KEEP: assert property (up_q && !healthy && !fault_clear_input && !awvalid && !bvalid
    && !wvalid |=> !healthy)
    else $error("fault dropped without clear");
  AST_MEM: assert property (mem_q |-> !healthy)
    else $error("power-cycle fault released");
  AST_SYS: assert property (sys_q |-> fault_led)
    else $error("system fault lamp not solid");
  AST_CLR: assert property (up_q && !healthy && !mem_q && !oth && !overload_det
    && $rose(fault_clear_input) |=> healthy)
    else $error("clear pulse ignored");
  AST_OVT: assert property (overload_det && ovc_q == OVLD_CYC - 1 |=> !healthy)
    else $error("overload not tripped");
  AST_OVE: assert property (healthy && !oth && ovc_q < OVLD_CYC - 1 |=> healthy)
    else $error("early trip");
  cover property (up_q && $rose(healthy));
  cover property ($fell(healthy));
  cover property (mem_q && fault_clear_input);
endmodule : sdf_top_props
bind sdf_top sdf_top_props #(.OVLD_CYC(OVLD_CYC)) sdf_top_props_i (
  .clk(clk),
  .rstn(rstn),
  .fault_clear_input(fault_clear_input),
  .overload_det(overload_det),
  .overvoltage_det(overvoltage_det),
  .speed_error_det(speed_error_det),
  .shaft_rpm(shaft_rpm),
  .param_corrupt_det(param_corrupt_det),
  .motor_cable_present(motor_cable_present),
  .system_fail_det(system_fail_det),
  .current_pct(current_pct),
  .motor_current_en(motor_current_en),
  .healthy(healthy),
  .fault_led(fault_led),
  .awvalid(awvalid),
  .wvalid(wvalid),
  .bvalid(bvalid)
);
`default_nettype wire

// ---- testbench/sdf_top_test.sv ----
// sdf_top_test: self-checking bench of sdf_top
// assumes shortened overload and blink counts
`default_nettype none
module sdf_top_test;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int OV = 20;
  localparam int BL = 4;
  localparam int PA = 12;
  logic clk = 1'b0;
  logic rstn = 1'b0;
  logic [3:0] cdial = 4'h0, fdial = 4'h0, len = 4'h1;
  logic ov = 1'b0, sp = 1'b0, pm = 1'b0, sf = 1'b0, ol = 1'b0, cab = 1'b1, go = 1'b0;
  logic [15:0] rpm = 16'h1388;
  logic [7:0] aw = 8'h00, ar = 8'h00;
  logic [31:0] wd = 32'h0;
  logic awv = 1'b0, wv = 1'b0, brdy = 1'b0, arv = 1'b0, rrdy = 1'b0;
  logic clr, cen, hl, led, irq, awr, wrdy, bv, arr, rv;
  logic [6:0] pct;
  logic [13:0] tc;
  logic [1:0] br, rr;
  logic [31:0] rd;
  int fails = 0, tests_run = 0;
  logic [6:0] pt [16] = '{7'h06, 7'h0d, 7'h13, 7'h19, 7'h1f, 7'h26, 7'h2c, 7'h32,
    7'h38, 7'h3f, 7'h45, 7'h4b, 7'h51, 7'h58, 7'h5e, 7'h64};
  logic [13:0] tt [16] = '{14'h0, 14'h00c, 14'h010, 14'h01b, 14'h029, 14'h052, 14'h078,
    14'h0a0, 14'h10e, 14'h19a, 14'h334, 14'h4b0, 14'h640, 14'ha8c, 14'h1004, 14'h2008};
  logic [3:0] cd [5] = '{4'h3, 4'h4, 4'h6, 4'h7, 4'hf};
  int nb [5] = '{3, 4, 6, 7, 1};
  always #20 clk = ~clk;
  sdf_ctl_model sdf_ctl_model_i (.clk(clk), .rstn(rstn), .go(go), .len(len), .clr(clr));
  sdf_top #(.OVLD_CYC(OV), .BLINK_CYC(BL), .PAUSE_CYC(PA)) sdf_top_i (
    .clk(clk), .rstn(rstn), .current_level_dial(cdial), .filter_dial(fdial),
    .fault_clear_input(clr), .overload_det(ol), .overvoltage_det(ov),
    .speed_error_det(sp), .shaft_rpm(rpm), .param_corrupt_det(pm),
    .motor_cable_present(cab), .system_fail_det(sf), .current_pct(pct),
    .motor_current_en(cen), .filter_tc(tc), .healthy(hl), .fault_led(led), .irq(irq),
    .awaddr(aw), .awprot(3'h0), .awvalid(awv), .awready(awr), .wdata(wd),
    .wstrb(4'hf), .wvalid(wv), .wready(wrdy), .bresp(br), .bvalid(bv), .bready(brdy),
    .araddr(ar), .arprot(3'h0), .arvalid(arv), .arready(arr), .rdata(rd),
    .rresp(rr), .rvalid(rv), .rready(rrdy));
  // ----------------------------------------------------------------
  // tasks
  // ----------------------------------------------------------------
  task automatic final_report();
    if (fails == 0 && tests_run > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : final_report
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    tests_run++;
    if (g !== e) begin
      fails++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, g, e);
    end
  endtask : chk
  task automatic hang();
    fails++;
    final_report();
  endtask : hang
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
  endtask : cyc
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] e);
    int n;
    @(posedge clk);
    aw <= a;
    wd <= d;
    awv <= 1'b1;
    wv <= 1'b1;
    brdy <= 1'b1;
    for (n = 0; n < 50; n++) begin
      @(posedge clk);
      if (awr) awv <= 1'b0;
      if (wrdy) wv <= 1'b0;
      if (bv) break;
    end
    brdy <= 1'b0;
    if (n == 50) hang();
    chk(br, e);
    cyc(2);
  endtask : wr
  task automatic rc(input logic [7:0] a, input logic [31:0] m, input logic [31:0] x,
    input logic [1:0] e);
    int n;
    @(posedge clk);
    ar <= a;
    arv <= 1'b1;
    rrdy <= 1'b1;
    for (n = 0; n < 50; n++) begin
      @(posedge clk);
      if (arr) arv <= 1'b0;
      if (rv) break;
    end
    rrdy <= 1'b0;
    if (n == 50) hang();
    chk(rd & m, x);
    chk(rr, e);
  endtask : rc
  task automatic det(input int k, input logic v);
    case (k)
      0: ov <= v;
      1: sp <= v;
      2: rpm <= v ? 16'h1389 : 16'h1388;
      3: pm <= v;
      default: sf <= v;
    endcase
  endtask : det
  task automatic pulse(input logic [3:0] l);
    @(posedge clk);
    go <= 1'b1;
    len <= l;
    @(posedge clk);
    go <= 1'b0;
    cyc(8);
  endtask : pulse
  task automatic rst();
    @(posedge clk);
    rstn <= 1'b0;
    cyc(3);
    rstn <= 1'b1;
    cyc(2);
  endtask : rst
  // ----------------------------------------------------------------
  // sequence
  // ----------------------------------------------------------------
  initial begin
    int k;
    int h;
    cyc(2);
    chk(pct, 7'h64);
    chk(tc, 14'h078);
    cyc(1);
    rstn <= 1'b1;
    for (k = 0; k < 16; k++) begin
      @(posedge clk);
      cdial <= k[3:0];
      fdial <= k[3:0];
      cyc(2);
      chk(pct, pt[k]);
      chk(tc, tt[k]);
    end
    chk(hl, 1'b1);
    wr(8'h04, 32'h0, 2'h2);
    rc(8'h14, 32'hffffffff, 32'h0, 2'h2);
    for (k = 0; k < 5; k++) begin
      wr(8'h0c, 32'h0, 2'h0);
      wr(8'h10, 32'h3, 2'h0);
      @(posedge clk);
      det(k, 1'b1);
      @(posedge clk);
      det(k, 1'b0);
      h = 0;
      repeat (nb[k] * 2 * BL - BL + PA) begin
        @(negedge clk);
        h += led;
      end
      chk(h, (k == 4) ? 16 : nb[k] * BL);
      chk({cen, hl, pct}, 9'h0);
      chk(irq, 1'b0);
      rc(8'h04, 32'hf, cd[k], 2'h0);
      rc(8'h08, 32'h3, 32'h1, 2'h0);
      wr(8'h0c, 32'h1, 2'h0);
      chk(irq, 1'b1);
      wr(8'h10, 32'h1, 2'h0);
      chk(irq, 1'b0);
      cyc(3);
      chk(hl, 1'b0);
      pulse(k[0] ? 4'h5 : 4'h1);
      chk(hl, k < 3);
      rc(8'h08, 32'h2, (k < 3) ? 32'h2 : 32'h0, 2'h0);
      if (k > 2) rst();
      chk(hl, 1'b1);
    end
    cab <= 1'b0;
    rst();
    cab <= 1'b1;
    chk(hl, 1'b0);
    rc(8'h04, 32'hf, 32'h8, 2'h0);
    pulse(4'h1);
    chk(hl, 1'b1);
    @(posedge clk);
    ol <= 1'b1;
    cyc(OV - 1);
    ol <= 1'b0;
    cyc(2);
    chk(hl, 1'b1);
    ol <= 1'b1;
    cyc(OV);
    ol <= 1'b0;
    cyc(2);
    chk(hl, 1'b0);
    rc(8'h04, 32'hf, 32'h2, 2'h0);
    wr(8'h00, 32'h1, 2'h0);
    chk(hl, 1'b1);
    final_report();
  end
endmodule : sdf_top_test
`default_nettype wire
